// ==== include/tcsg_pkg.sv ====
package tcsg_pkg;

  localparam int IDX_W      = 4;
  localparam int FINE_W     = 8;
  localparam int COARSE_W   = 4;
  localparam int TONE_PER_W = 12;
  localparam int NOISE_W    = 5;
  localparam int AMP_W      = 5;
  localparam int ENV_PER_W  = 16;
  localparam int SHAPE_W    = 4;
  localparam int LEVEL_W    = 4;
  localparam int LFSR_W     = 17;

  localparam logic [3:0] IDX_TONE_A_FINE   = 4'h0;
  localparam logic [3:0] IDX_TONE_A_COARSE = 4'h1;
  localparam logic [3:0] IDX_TONE_B_FINE   = 4'h2;
  localparam logic [3:0] IDX_TONE_B_COARSE = 4'h3;
  localparam logic [3:0] IDX_TONE_C_FINE   = 4'h4;
  localparam logic [3:0] IDX_TONE_C_COARSE = 4'h5;
  localparam logic [3:0] IDX_NOISE_PERIOD  = 4'h6;
  localparam logic [3:0] IDX_MIXER         = 4'h7;
  localparam logic [3:0] IDX_AMP_A         = 4'h8;
  localparam logic [3:0] IDX_AMP_B         = 4'h9;
  localparam logic [3:0] IDX_AMP_C         = 4'hA;
  localparam logic [3:0] IDX_ENV_LOW       = 4'hB;
  localparam logic [3:0] IDX_ENV_HIGH      = 4'hC;
  localparam logic [3:0] IDX_ENV_SHAPE     = 4'hD;
  localparam logic [3:0] IDX_PORT_A        = 4'hE;
  localparam logic [3:0] IDX_PORT_B        = 4'hF;

  localparam int AMP_ENV_BIT   = 4;
  localparam int MIX_TONE_LSB  = 0;
  localparam int MIX_NOISE_LSB = 3;
  localparam int SHAPE_HOLD    = 0;
  localparam int SHAPE_ALT     = 1;
  localparam int SHAPE_ATTACK  = 2;
  localparam int SHAPE_CONT    = 3;

  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_MIXER  = 8'h3F;
  localparam logic [16:0] LFSR_SEED  = 17'h00001;
  localparam int          CLK_DIV    = 8;

  typedef enum {BUS_IDLE, BUS_LATCH, BUS_WRITE, BUS_READ} tcsg_bus_op_t;

  // A period of zero behaves as one
  function automatic logic [15:0] tcsg_period(input logic [15:0] p);
    tcsg_period = (p == 16'h0000) ? 16'h0001 : p;
  endfunction

  function automatic tcsg_bus_op_t tcsg_decode(input logic dir, input logic bc1);
    if (dir && bc1) begin
      tcsg_decode = BUS_LATCH;
    end else if (dir) begin
      tcsg_decode = BUS_WRITE;
    end else if (bc1) begin
      tcsg_decode = BUS_READ;
    end else begin
      tcsg_decode = BUS_IDLE;
    end
  endfunction

endpackage

// ==== logic/tcsg_tone.sv ====
`timescale 1ns/1ps
module tcsg_tone #(
  parameter int PER_W = 16
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             tick_in,
  input  wire logic [PER_W-1:0] period_in,
  output logic                  square_out
);
  import tcsg_pkg::*;

  logic [PER_W-1:0] cnt_reg;
  logic [15:0]      per_ext;
  logic [15:0]      per_min;

  assign per_ext = 16'(period_in);
  assign per_min = tcsg_period(per_ext);

  // Toggle once per period; period shrinks take effect at once
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_reg    <= '0;
      square_out <= 1'b0;
    end else if (tick_in) begin
      if (16'(cnt_reg) + 16'h0001 >= per_min) begin
        cnt_reg    <= '0;
        square_out <= ~square_out;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule // tcsg_tone

// ==== logic/tcsg_env.sv ====
`timescale 1ns/1ps
module tcsg_env (
  input  wire logic                          ref_clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          tick_in,
  input  wire logic                          restart_in,
  input  wire logic [tcsg_pkg::ENV_PER_W-1:0] period_in,
  input  wire logic [tcsg_pkg::SHAPE_W-1:0]   shape_in,
  output logic      [tcsg_pkg::LEVEL_W-1:0]   level_out
);
  import tcsg_pkg::*;

  logic [ENV_PER_W-1:0] div_reg;
  logic [3:0]           step_reg;
  logic                 att_reg;
  logic                 hold_reg;
  logic                 step_tick;

  assign step_tick = tick_in && ((div_reg + 1'b1) >= tcsg_period(period_in));

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || restart_in) begin
      div_reg <= '0;
    end else if (tick_in) begin
      div_reg <= step_tick ? '0 : div_reg + 1'b1;
    end
  end

  // Shape: continue, attack, alternate, hold
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      step_reg <= 4'h0;
      att_reg  <= 1'b0;
      hold_reg <= 1'b1;
    end else if (restart_in) begin
      step_reg <= 4'h0;
      att_reg  <= shape_in[SHAPE_ATTACK];
      hold_reg <= 1'b0;
    end else if (step_tick && !hold_reg) begin
      if (step_reg != 4'hF) begin
        step_reg <= step_reg + 4'h1;
      end else if (!shape_in[SHAPE_CONT]) begin
        // One sweep then silence
        att_reg  <= 1'b0;
        hold_reg <= 1'b1;
      end else if (shape_in[SHAPE_HOLD]) begin
        att_reg  <= att_reg ^ shape_in[SHAPE_ALT];
        hold_reg <= 1'b1;
      end else begin
        step_reg <= 4'h0;
        att_reg  <= att_reg ^ shape_in[SHAPE_ALT];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      level_out <= 4'h0;
    end else begin
      level_out <= att_reg ? step_reg : ~step_reg;
    end
  end

endmodule // tcsg_env

// ==== logic/tcsg_top.sv ====
`timescale 1ns/1ps
module tcsg_top #(
  parameter int DIV_CYCLES = tcsg_pkg::CLK_DIV
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        bus_direction_ctl_in,
  input  wire logic                        bus_control_one_in,
  input  wire logic [7:0]                  data_in,
  output logic      [7:0]                  data_out,
  output logic                             data_oe_out,
  input  wire logic [7:0]                  port_a_in,
  output logic      [7:0]                  port_b_out,
  output logic      [tcsg_pkg::LEVEL_W-1:0] level_a_out,
  output logic      [tcsg_pkg::LEVEL_W-1:0] level_b_out,
  output logic      [tcsg_pkg::LEVEL_W-1:0] level_c_out
);
  import tcsg_pkg::*;

  // Bus side
  tcsg_bus_op_t           bus_op;
  tcsg_bus_op_t           prev_op_reg;
  logic [IDX_W-1:0]       index_reg;
  logic                   wr_en;
  logic                   wr_first;

  // Register file
  logic [FINE_W-1:0]      fine_a_reg;
  logic [FINE_W-1:0]      fine_b_reg;
  logic [FINE_W-1:0]      fine_c_reg;
  logic [COARSE_W-1:0]    coarse_a_reg;
  logic [COARSE_W-1:0]    coarse_b_reg;
  logic [COARSE_W-1:0]    coarse_c_reg;
  logic [NOISE_W-1:0]     noise_per_reg;
  logic [7:0]             mixer_reg;
  logic [AMP_W-1:0]       amp_a_reg;
  logic [AMP_W-1:0]       amp_b_reg;
  logic [AMP_W-1:0]       amp_c_reg;
  logic [7:0]             env_low_reg;
  logic [7:0]             env_high_reg;
  logic [SHAPE_W-1:0]     shape_reg;
  logic [7:0]             port_b_reg;
  logic [7:0]             read_next;

  // Timebase
  logic [7:0]             div_reg;
  logic                   tick_reg;
  logic                   half_reg;
  logic                   slow_tick;

  // Sound sources
  logic [TONE_PER_W-1:0]  per_a;
  logic [TONE_PER_W-1:0]  per_b;
  logic [TONE_PER_W-1:0]  per_c;
  logic                   sq_a;
  logic                   sq_b;
  logic                   sq_c;
  logic [NOISE_W-1:0]     noise_cnt_reg;
  logic [LFSR_W-1:0]      lfsr_reg;
  logic                   noise_bit;
  logic                   env_restart;
  logic [LEVEL_W-1:0]     env_level;
  logic [2:0]             gate;

  // Decoding is combinational from the two control inputs
  assign bus_op = tcsg_decode(bus_direction_ctl_in, bus_control_one_in);
  assign wr_en  = (bus_op == BUS_WRITE);

  // Held write strobes rewrite the same value; only shape needs the edge
  assign wr_first = wr_en && (prev_op_reg != BUS_WRITE);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prev_op_reg <= BUS_IDLE;
    end else begin
      prev_op_reg <= bus_op;
    end
  end

  // Index only moves on a latch cycle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      index_reg <= '0;
    end else if (bus_op == BUS_LATCH) begin
      index_reg <= data_in[IDX_W-1:0];
    end
  end

  // Tone periods
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      fine_a_reg   <= RST_BYTE;
      fine_b_reg   <= RST_BYTE;
      fine_c_reg   <= RST_BYTE;
      coarse_a_reg <= RST_BYTE[COARSE_W-1:0];
      coarse_b_reg <= RST_BYTE[COARSE_W-1:0];
      coarse_c_reg <= RST_BYTE[COARSE_W-1:0];
    end else if (wr_en) begin
      if (index_reg == IDX_TONE_A_FINE) begin
        fine_a_reg <= data_in;
      end else if (index_reg == IDX_TONE_A_COARSE) begin
        coarse_a_reg <= data_in[COARSE_W-1:0];
      end else if (index_reg == IDX_TONE_B_FINE) begin
        fine_b_reg <= data_in;
      end else if (index_reg == IDX_TONE_B_COARSE) begin
        coarse_b_reg <= data_in[COARSE_W-1:0];
      end else if (index_reg == IDX_TONE_C_FINE) begin
        fine_c_reg <= data_in;
      end else if (index_reg == IDX_TONE_C_COARSE) begin
        coarse_c_reg <= data_in[COARSE_W-1:0];
      end
    end
  end

  // Noise period and source enables
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      noise_per_reg <= RST_BYTE[NOISE_W-1:0];
      mixer_reg     <= RST_MIXER;
    end else if (wr_en) begin
      if (index_reg == IDX_NOISE_PERIOD) begin
        noise_per_reg <= data_in[NOISE_W-1:0];
      end else if (index_reg == IDX_MIXER) begin
        mixer_reg <= data_in;
      end
    end
  end

  // Amplitudes
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      amp_a_reg <= RST_BYTE[AMP_W-1:0];
      amp_b_reg <= RST_BYTE[AMP_W-1:0];
      amp_c_reg <= RST_BYTE[AMP_W-1:0];
    end else if (wr_en) begin
      if (index_reg == IDX_AMP_A) begin
        amp_a_reg <= data_in[AMP_W-1:0];
      end else if (index_reg == IDX_AMP_B) begin
        amp_b_reg <= data_in[AMP_W-1:0];
      end else if (index_reg == IDX_AMP_C) begin
        amp_c_reg <= data_in[AMP_W-1:0];
      end
    end
  end

  // Envelope period, shape and output port
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      env_low_reg  <= RST_BYTE;
      env_high_reg <= RST_BYTE;
      shape_reg    <= RST_BYTE[SHAPE_W-1:0];
      port_b_reg   <= RST_BYTE;
    end else if (wr_en) begin
      if (index_reg == IDX_ENV_LOW) begin
        env_low_reg <= data_in;
      end else if (index_reg == IDX_ENV_HIGH) begin
        env_high_reg <= data_in;
      end else if (index_reg == IDX_ENV_SHAPE) begin
        shape_reg <= data_in[SHAPE_W-1:0];
      end else if (index_reg == IDX_PORT_B) begin
        port_b_reg <= data_in;
      end
    end
  end

  // Port A is input only, so writes to its index are dropped
  assign env_restart = wr_first && (index_reg == IDX_ENV_SHAPE);

  // Read mux; unused upper bits read as zero
  always_comb begin
    read_next = 8'h00;
    if (index_reg == IDX_TONE_A_FINE) begin
      read_next = fine_a_reg;
    end else if (index_reg == IDX_TONE_A_COARSE) begin
      read_next = {4'h0, coarse_a_reg};
    end else if (index_reg == IDX_TONE_B_FINE) begin
      read_next = fine_b_reg;
    end else if (index_reg == IDX_TONE_B_COARSE) begin
      read_next = {4'h0, coarse_b_reg};
    end else if (index_reg == IDX_TONE_C_FINE) begin
      read_next = fine_c_reg;
    end else if (index_reg == IDX_TONE_C_COARSE) begin
      read_next = {4'h0, coarse_c_reg};
    end else if (index_reg == IDX_NOISE_PERIOD) begin
      read_next = {3'h0, noise_per_reg};
    end else if (index_reg == IDX_MIXER) begin
      read_next = mixer_reg;
    end else if (index_reg == IDX_AMP_A) begin
      read_next = {3'h0, amp_a_reg};
    end else if (index_reg == IDX_AMP_B) begin
      read_next = {3'h0, amp_b_reg};
    end else if (index_reg == IDX_AMP_C) begin
      read_next = {3'h0, amp_c_reg};
    end else if (index_reg == IDX_ENV_LOW) begin
      read_next = env_low_reg;
    end else if (index_reg == IDX_ENV_HIGH) begin
      read_next = env_high_reg;
    end else if (index_reg == IDX_ENV_SHAPE) begin
      read_next = {4'h0, shape_reg};
    end else if (index_reg == IDX_PORT_A) begin
      read_next = port_a_in;
    end else begin
      read_next = port_b_reg;
    end
  end

  // Data driven one cycle after the read op is seen
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      data_out    <= (bus_op == BUS_READ) ? read_next : 8'h00;
      data_oe_out <= (bus_op == BUS_READ);
    end
  end

  // Port B always drives; bit 7 steers the joystick mux outside
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      port_b_out <= RST_BYTE;
    end else begin
      port_b_out <= port_b_reg;
    end
  end

  // Prescaler: tick each DIV_CYCLES, slow tick at half that rate
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_reg == 8'(DIV_CYCLES - 1)) begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      half_reg <= 1'b0;
    end else if (tick_reg) begin
      half_reg <= ~half_reg;
    end
  end

  assign slow_tick = tick_reg && half_reg;

  assign per_a = {coarse_a_reg, fine_a_reg};
  assign per_b = {coarse_b_reg, fine_b_reg};
  assign per_c = {coarse_c_reg, fine_c_reg};

  // Three identical tone channels
  tcsg_tone #(.PER_W(TONE_PER_W)) u_tone_a (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick_reg),
    .period_in  (per_a),
    .square_out (sq_a)
  );

  tcsg_tone #(.PER_W(TONE_PER_W)) u_tone_b (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick_reg),
    .period_in  (per_b),
    .square_out (sq_b)
  );

  tcsg_tone #(.PER_W(TONE_PER_W)) u_tone_c (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (tick_reg),
    .period_in  (per_c),
    .square_out (sq_c)
  );

  // Noise: LFSR shifts once per noise period of slow ticks
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      noise_cnt_reg <= '0;
      lfsr_reg      <= LFSR_SEED;
    end else if (slow_tick) begin
      if (16'(noise_cnt_reg) + 16'h0001
          >= tcsg_period(16'(noise_per_reg))) begin
        noise_cnt_reg <= '0;
        lfsr_reg      <= {lfsr_reg[0] ^ lfsr_reg[3], lfsr_reg[LFSR_W-1:1]};
      end else begin
        noise_cnt_reg <= noise_cnt_reg + 1'b1;
      end
    end
  end

  assign noise_bit = lfsr_reg[0];

  tcsg_env u_env (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (slow_tick),
    .restart_in (env_restart),
    .period_in  ({env_high_reg, env_low_reg}),
    .shape_in   (shape_reg),
    .level_out  (env_level)
  );

  // A disabled source counts as always high, so both off gives a steady level
  always_comb begin
    gate[0] = (sq_a | mixer_reg[MIX_TONE_LSB])
            & (noise_bit | mixer_reg[MIX_NOISE_LSB]);
    gate[1] = (sq_b | mixer_reg[MIX_TONE_LSB + 1])
            & (noise_bit | mixer_reg[MIX_NOISE_LSB + 1]);
    gate[2] = (sq_c | mixer_reg[MIX_TONE_LSB + 2])
            & (noise_bit | mixer_reg[MIX_NOISE_LSB + 2]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      level_a_out <= '0;
      level_b_out <= '0;
      level_c_out <= '0;
    end else begin
      level_a_out <= !gate[0] ? 4'h0
                   : amp_a_reg[AMP_ENV_BIT] ? env_level
                   : amp_a_reg[LEVEL_W-1:0];
      level_b_out <= !gate[1] ? 4'h0
                   : amp_b_reg[AMP_ENV_BIT] ? env_level
                   : amp_b_reg[LEVEL_W-1:0];
      level_c_out <= !gate[2] ? 4'h0
                   : amp_c_reg[AMP_ENV_BIT] ? env_level
                   : amp_c_reg[LEVEL_W-1:0];
    end
  end

endmodule // tcsg_top

// ==== verification/tcsg_top_asserts.sv ====
`timescale 1ns/1ps
module tcsg_top_asserts #(
  parameter int DIV_CYCLES = 8
) (
  input wire logic       ref_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       bus_direction_ctl_in,
  input wire logic       bus_control_one_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_out,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_out,
  input wire logic [3:0] level_a_out,
  input wire logic [3:0] level_b_out,
  input wire logic [3:0] level_c_out
);
  import tcsg_pkg::*;
  logic       rd;
  logic       wr;
  logic       lt;
  logic [3:0] idx_reg;
  logic [7:0] mix_reg;
  logic [4:0] amp_reg;
  assign rd = !bus_direction_ctl_in && bus_control_one_in;
  assign wr = bus_direction_ctl_in && !bus_control_one_in;
  assign lt = bus_direction_ctl_in && bus_control_one_in;
  // Shadow of the index, mixer and amplitude A so levels can be judged
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      idx_reg <= 4'h0;
    end else if (lt) begin
      idx_reg <= data_in[3:0];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mix_reg <= 8'h3F;
    end else if (wr && idx_reg == 4'h7) begin
      mix_reg <= data_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      amp_reg <= 5'h00;
    end else if (wr && idx_reg == 4'h8) begin
      amp_reg <= data_in[4:0];
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_read_drives_bus: assert property (rd |=> data_oe_out)
    else $error("read did not drive the data bus");
  a_idle_bus_quiet: assert property (!rd |=> !data_oe_out && data_out == 8'h00)
    else $error("data bus driven outside a read");
  a_port_a_read: assert property (rd && idx_reg == 4'hE |=> data_out == $past(port_a_in))
    else $error("port A read mismatch");
  // Port B output is a second register stage, so it lags a write by two edges
  a_port_b_write: assert property (wr && idx_reg == 4'hF |=> ##1 port_b_out == $past(data_in, 2))
    else $error("port B write not seen on port");
  a_port_b_hold: assert property (!(wr && idx_reg == 4'hF) |=> ##1 $stable(port_b_out))
    else $error("port B changed without a write");
  a_mixer_read: assert property (rd && idx_reg == 4'h7 |=> data_out == $past(mix_reg))
    else $error("mixer read back wrong");
  a_narrow_read: assert property (rd && (idx_reg == 4'h1 || idx_reg == 4'h3 || idx_reg == 4'h5
    || idx_reg == 4'hD) |=> data_out[7:4] == 4'h0)
    else $error("upper nibble of a 4-bit register not zero");
  a_fixed_level: assert property ((mix_reg[0] && mix_reg[3] && !amp_reg[4] && $stable(amp_reg)
    && $stable(mix_reg)) [*2] |-> level_a_out == amp_reg[3:0])
    else $error("fixed level A does not follow amplitude");
endmodule // tcsg_top_asserts
bind tcsg_top tcsg_top_asserts #(.DIV_CYCLES(DIV_CYCLES)) tcsg_top_asserts_inst (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .bus_direction_ctl_in(bus_direction_ctl_in), .bus_control_one_in(bus_control_one_in),
  .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .port_a_in(port_a_in), .port_b_out(port_b_out), .level_a_out(level_a_out),
  .level_b_out(level_b_out), .level_c_out(level_c_out));

// ==== verification/tcsg_host_model.sv ====
`timescale 1ns/1ps
module tcsg_host_model (
  input  wire logic [1:0] addr_in,
  input  wire logic       select_n_in,
  input  wire logic       io_request_strobe_n_in,
  input  wire logic       port_sel_in,
  input  wire logic [7:0] first_joystick_connector_in,
  input  wire logic [7:0] second_joystick_connector_in,
  output logic            bus_direction_ctl_out,
  output logic            bus_control_one_out,
  output logic      [7:0] port_a_out
);
  logic enable;
  // Controls stay low unless decoded and strobed, so no stray ops
  assign enable = !select_n_in && !io_request_strobe_n_in;
  assign bus_direction_ctl_out = enable && !addr_in[1];
  assign bus_control_one_out = enable && !addr_in[0];
  assign port_a_out = port_sel_in ? second_joystick_connector_in
                                  : first_joystick_connector_in;
endmodule // tcsg_host_model

// ==== verification/tcsg_top_test.sv ====
`timescale 1ns/1ps
module tcsg_top_test;
  import tcsg_pkg::*;
  localparam int DIV = 2;
  logic       ref_clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic [1:0] addr       = 2'b11;
  logic       select_n   = 1'b1;
  logic       io_req_n   = 1'b1;
  logic [7:0] data_in    = 8'h00;
  logic [7:0] joy1       = 8'h5A;
  logic [7:0] joy2       = 8'hA5;
  logic       dir;
  logic       bc1;
  logic [7:0] data_out;
  logic       data_oe_out;
  logic [7:0] port_a;
  logic [7:0] port_b_out;
  logic [3:0] lvl [3];
  int         n_mismatch  = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  tcsg_host_model tcsg_host_model_inst (.addr_in(addr), .select_n_in(select_n),
    .io_request_strobe_n_in(io_req_n), .port_sel_in(port_b_out[7]),
    .first_joystick_connector_in(joy1), .second_joystick_connector_in(joy2),
    .bus_direction_ctl_out(dir), .bus_control_one_out(bc1), .port_a_out(port_a));
  tcsg_top #(.DIV_CYCLES(DIV)) tcsg_top_inst (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .bus_direction_ctl_in(dir), .bus_control_one_in(bc1),
    .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out), .port_a_in(port_a),
    .port_b_out(port_b_out), .level_a_out(lvl[0]), .level_b_out(lvl[1]),
    .level_c_out(lvl[2]));
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Limit well above the longest expected run
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Address 00 latch, 01 write, 10 read; released bus shows the inverse
  task automatic cyc(input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk_in);
    addr = a;
    select_n = 1'b0;
    io_req_n = 1'b0;
    data_in = d;
    @(negedge ref_clk_in);
    q = data_out;
    if (a == 2'b10) check("read enable", 16'h0001, {15'h0000, data_oe_out});
    select_n = 1'b1;
    io_req_n = 1'b1;
    data_in = ~d;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    cyc(2'b00, {4'h0, i}, q);
    cyc(2'b01, d, q);
  endtask
  task automatic rd(input logic [3:0] i, output logic [7:0] q);
    cyc(2'b00, {4'h0, i}, q);
    cyc(2'b10, 8'hC3, q);
  endtask
  task automatic t_reset();
    logic [7:0] q;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], q);
      check("reset value", (i == 7) ? 8'h3F : (i == 14) ? joy1 : 8'h00, q);
    end
  endtask
  task automatic t_tone();
    logic [3:0] lv;
    int         n;
    for (int ch = 0; ch < 3; ch++) begin
      wr(4'(2 * ch), 8'h03);
      wr(4'(2 * ch + 1), 8'h01);
      wr(4'(8 + ch), 8'h0F);
      wr(4'h7, 8'h3F & ~(8'h01 << ch));
      // Two syncs so a period still counting from before is flushed
      for (int k = 0; k < 3; k++) begin
        lv = lvl[ch];
        n = 0;
        while (lvl[ch] === lv && n < 1200) begin
          @(negedge ref_clk_in);
          n++;
        end
      end
      check("tone half period", 16'(259 * DIV), 16'(n));
    end
  endtask
  task automatic t_persist();
    logic [7:0] q;
    wr(4'h2, 8'h5A);
    cyc(2'b01, 8'h3C, q);
    cyc(2'b11, 8'h99, q);
    cyc(2'b10, 8'h00, q);
    check("index kept", 8'h3C, q);
    cyc(2'b10, 8'h00, q);
    check("index kept again", 8'h3C, q);
  endtask
  task automatic t_widths();
    logic [7:0] msk [16] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h1F, 8'hFF,
                             8'h1F, 8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'hFF};
    logic [7:0] q;
    for (int i = 0; i < 16; i++) wr(i[3:0], 8'hFF);
    // Port pins follow the register one edge later
    @(negedge ref_clk_in);
    check("port B out", 8'hFF, port_b_out);
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], q);
      check("masked read", (i == 14) ? joy2 : msk[i], q);
    end
  endtask
  task automatic t_levels();
    wr(4'h7, 8'h3F);
    wr(4'hB, 8'h01);
    wr(4'hC, 8'h00);
    wr(4'h8, 8'h0A);
    repeat (3) @(negedge ref_clk_in);
    check("fixed level", 4'hA, lvl[0]);
    wr(4'hD, 8'h0D);
    wr(4'h8, 8'h1A);
    repeat (200) @(negedge ref_clk_in);
    check("rising envelope level", 4'hF, lvl[0]);
    wr(4'hD, 8'h00);
    repeat (200) @(negedge ref_clk_in);
    check("falling envelope level", 4'h0, lvl[0]);
  endtask
  // Noise alone on A: a live shift register must show both levels
  task automatic t_noise();
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    wr(4'h6, 8'h01);
    wr(4'h8, 8'h0F);
    wr(4'h7, 8'h37);
    repeat (400) begin
      @(negedge ref_clk_in);
      if (lvl[0] === 4'h0) lo++;
      if (lvl[0] === 4'hF) hi++;
    end
    check("noise low seen", 16'h0001, {15'h0000, lo > 0});
    check("noise high seen", 16'h0001, {15'h0000, hi > 0});
  endtask
  initial begin
    repeat (12) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_tone();
    t_persist();
    t_widths();
    t_levels();
    t_noise();
    conclude();
  end
endmodule // tcsg_top_test
